// >>> shared/i2c_flag_defs.vh
// constants for the two-wire status flag block
`ifndef I2C_FLAG_DEFS_VH
`define I2C_FLAG_DEFS_VH
`define FLAG_STATUS_ADDR   4'h0
`define FLAG_CONTROL_ADDR  4'h4
`define FLAG_AL_BIT        2
`define FLAG_AAS_BIT       1
`define FLAG_GC_BIT        0
`define CTRL_ADDR_LSB      0
`define CTRL_ADDR_MSB      6
`define CTRL_MASTER_BIT    8
`define CTRL_TRANSMIT_BIT  9
`define CTRL_CLKSYNC_BIT   10
`define CTRL_RESET_VAL     32'h00000000
`define FRAME_BITS         4'h9
`define GC_ADDRESS         7'h00
`endif

// >>> hw/sync_edge.v
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
module sync_edge (
    input  wire clk_i,
    input  wire rst_i,
    input  wire async_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta_r;
    reg sync_r;
    reg prev_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end
    assign level_o = sync_r;
    assign rise_o  = sync_r & ~prev_r;
    assign fall_o  = ~sync_r & prev_r;
endmodule // sync_edge

// >>> hw/i2c_status_flags.v
// status flags of the two-wire interface with wishbone slave
//
// Summary of operation
// - master transmit, driven data mismatch at clock rise
// - master mode, start seen while driving high
// - clocked sync, last bit while receive full
// - arbitration flag cleared by 0 after read 1
// - slave receive, first frame matches own address
// - slave receive, general call sets address match
// - address match cleared by 0 after read 1
// - slave receive, general call sets general call flag
// - general call flag cleared by 0 after read 1
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "i2c_flag_defs.vh"
module i2c_status_flags (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        scl_i,
    input  wire        sda_i,
    input  wire        sda_drive_i,
    input  wire        receive_full_flag_i,
    output wire [2:0]  flags_o
);
    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    wire scl_s;
    wire scl_rise;
    wire scl_fall;
    wire sda_s;
    wire sda_rise;
    wire sda_fall;
    sync_edge u_scl (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (scl_i),
        .level_o (scl_s),
        .rise_o  (scl_rise),
        .fall_o  (scl_fall)
    );
    sync_edge u_sda (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (sda_i),
        .level_o (sda_s),
        .rise_o  (sda_rise),
        .fall_o  (sda_fall)
    );
    //------------------------------------------------------------
    // control register
    //------------------------------------------------------------
    reg  [31:0] ctrl_r;
    wire [6:0]  own_slave_address = ctrl_r[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
    wire        master_mode       = ctrl_r[`CTRL_MASTER_BIT];
    wire        transmit_mode     = ctrl_r[`CTRL_TRANSMIT_BIT];
    wire        clksync_mode      = ctrl_r[`CTRL_CLKSYNC_BIT];
    wire        slave_rx_mode     = ~master_mode & ~transmit_mode & ~clksync_mode;
    //------------------------------------------------------------
    // bus events and frame shifter
    //------------------------------------------------------------
    wire       start_det = sda_fall & scl_s & ~clksync_mode;
    wire       stop_det  = sda_rise & scl_s & ~clksync_mode;
    reg  [3:0] bit_cnt_r;
    reg  [7:0] shift_r;
    reg        first_frame_r;
    wire [3:0] frame_len = clksync_mode ? 4'h8 : `FRAME_BITS;
    wire       last_bit  = scl_rise & (bit_cnt_r == frame_len - 4'h1);
    wire       addr_done = scl_rise & first_frame_r & (bit_cnt_r == 4'h7);
    wire [7:0] addr_byte = {shift_r[6:0], sda_s};
    always @(posedge clk_i) begin
        if (rst_i) begin
            bit_cnt_r     <= 4'h0;
            shift_r       <= 8'h00;
            first_frame_r <= 1'b0;
        end else if (start_det) begin
            bit_cnt_r     <= 4'h0;
            first_frame_r <= 1'b1;
        end else if (stop_det) begin
            bit_cnt_r     <= 4'h0;
            first_frame_r <= 1'b0;
        end else if (scl_rise) begin
            shift_r <= addr_byte;
            if (last_bit) begin
                bit_cnt_r     <= 4'h0;
                first_frame_r <= 1'b0;
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end
    wire own_match = addr_done & (addr_byte[7:1] == own_slave_address);
    wire gc_match  = addr_done & (addr_byte[7:1] == `GC_ADDRESS) & ~addr_byte[0];
    wire set_al  = (master_mode & transmit_mode & ~clksync_mode & scl_rise
                    & (sda_drive_i != sda_s))
                 | (master_mode & start_det & sda_drive_i)
                 | (clksync_mode & last_bit & receive_full_flag_i);
    wire set_aas = slave_rx_mode & (own_match | gc_match);
    wire set_gc  = slave_rx_mode & gc_match;
    //------------------------------------------------------------
    // flags with read-one then write-zero clear
    //------------------------------------------------------------
    reg  [2:0] flag_r;
    reg  [2:0] armed_r;
    wire [2:0] set_vec = {set_al, set_aas, set_gc};
    wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       st_sel  = (wb_adr_i == `FLAG_STATUS_ADDR);
    wire       st_wr   = req & wb_we_i & st_sel & wb_sel_i[0];
    wire       st_rd   = req & ~wb_we_i & st_sel;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_flag
            always @(posedge clk_i) begin
                if (rst_i) begin
                    flag_r[g]  <= 1'b0;
                    armed_r[g] <= 1'b0;
                end else begin
                    if (set_vec[g]) begin
                        flag_r[g] <= 1'b1;
                    end else if (st_wr & ~wb_dat_i[g] & armed_r[g]) begin
                        flag_r[g] <= 1'b0;
                    end
                    if (st_rd & flag_r[g]) begin
                        armed_r[g] <= 1'b1;
                    end else if (st_wr | ~flag_r[g]) begin
                        armed_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign flags_o = flag_r;
    //------------------------------------------------------------
    // wishbone slave
    //------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= `CTRL_RESET_VAL;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req & ~wb_we_i) begin
                if (st_sel) begin
                    wb_dat_o <= {29'h0, flag_r};
                end else if (wb_adr_i == `FLAG_CONTROL_ADDR) begin
                    wb_dat_o <= {21'h0, ctrl_r[10:8], 1'b0, ctrl_r[6:0]};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
            if (req & wb_we_i & (wb_adr_i == `FLAG_CONTROL_ADDR)) begin
                if (wb_sel_i[0]) begin
                    ctrl_r[6:0] <= wb_dat_i[6:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl_r[10:8] <= wb_dat_i[10:8];
                end
            end
        end
    end
endmodule // i2c_status_flags

// >>> sim/i2c_bus_model.sv
// other party on the two-wire bus, lines pulled up when released
`timescale 1ns/1ps
module i2c_bus_model (
    output logic scl_o,
    output logic sda_o
);
initial scl_o = 1'b1;
initial sda_o = 1'b1;
task automatic start_cond();
    #160 sda_o = 1'b0;
    #160 scl_o = 1'b0;
endtask
task automatic send_bits(input logic [8:0] v, input int n);
    scl_o = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
        #80 sda_o = v[k];
        #80 scl_o = 1'b1;
        #160 scl_o = 1'b0;
    end
    sda_o = 1'b1;
endtask
task automatic stop_cond();
    sda_o = 1'b0;
    #160 scl_o = 1'b1;
    #160 sda_o = 1'b1;
    #160;
endtask
endmodule // i2c_bus_model

// >>> sim/i2c_status_flags_monitor.sv
// checker for the two-wire status flag block
`timescale 1ns/1ps
module i2c_status_flags_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [2:0]  flags_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire wr_w = wb_cyc_i && wb_stb_i && wb_we_i;
sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
a_ack_one_pulse: assert property (taken_s |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
a_reset_clears: assert property (disable iff (1'b0) rst_i |=> flags_o == 3'h0 && !wb_ack_o)
    else $error("reset left flags or ack set");
a_al_clear_write: assert property ($fell(flags_o[2]) |-> $past(wr_w))
    else $error("arbitration flag fell without write");
a_aas_clear_write: assert property ($fell(flags_o[1]) |-> $past(wr_w))
    else $error("address match flag fell without write");
a_gc_clear_write: assert property ($fell(flags_o[0]) |-> $past(wr_w))
    else $error("general call flag fell without write");
a_gc_sets_match: assert property ($rose(flags_o[0]) |-> flags_o[1])
    else $error("general call without address match");
a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 4'h0
    && wb_adr_i != 4'h4 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // i2c_status_flags_monitor
bind i2c_status_flags i2c_status_flags_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flags_o(flags_o));

// >>> sim/i2c_status_flags_test.sv
// self-checking bench for the two-wire status flag block
`timescale 1ns/1ps
module i2c_status_flags_test;
logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
logic        sda_drive_i, receive_full_flag_i, scl_w, sda_w;
logic [3:0]  wb_adr_i, wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o, rd;
logic [2:0]  flags_o;
logic [7:0]  av [4] = '{8'h56, 8'h01, 8'h54, 8'h00};
logic [31:0] ev [4] = '{32'h0, 32'h0, 32'h2, 32'h3};
int          bad_count = 0;
int          n_tests = 0;
i2c_status_flags i_i2c_status_flags (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w),
    .sda_i(sda_w), .sda_drive_i(sda_drive_i), .receive_full_flag_i(receive_full_flag_i),
    .flags_o(flags_o));
i2c_bus_model i_i2c_bus_model (.scl_o(scl_w), .sda_o(sda_w));
initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
end
task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, d};
    do begin
        @(posedge clk_i);
        t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    rd = wb_dat_o;
    if (t >= 20) bad_count++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
endtask
task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
        bad_count++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic rchk(input string nm, input logic [3:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check(nm, rd, exp);
endtask
initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    sda_drive_i = 1'b1;
    receive_full_flag_i = 1'b0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("status", 4'h0, 32'h0);
    rchk("control", 4'h4, 32'h0);
    xfer(1'b1, 4'h8, 32'hff);
    rchk("unmapped", 4'h8, 32'h0);
    xfer(1'b1, 4'h4, 32'h2a);
    rchk("control", 4'h4, 32'h2a);
    for (int k = 0; k < 4; k++) begin
        i_i2c_bus_model.start_cond();
        i_i2c_bus_model.send_bits({av[k], 1'b1}, 9);
        i_i2c_bus_model.stop_cond();
        xfer(1'b1, 4'h0, 32'h0);
        rchk("status", 4'h0, ev[k]);
        xfer(1'b1, 4'h0, 32'h0);
    end
    rchk("status", 4'h0, 32'h0);
    xfer(1'b1, 4'h4, 32'h300);
    i_i2c_bus_model.start_cond();
    rchk("status", 4'h0, 32'h4);
    xfer(1'b1, 4'h0, 32'h0);
    rchk("status", 4'h0, 32'h0);
    i_i2c_bus_model.send_bits(9'h1ff, 9);
    rchk("status", 4'h0, 32'h0);
    i_i2c_bus_model.send_bits(9'h17f, 9);
    rchk("status", 4'h0, 32'h4);
    i_i2c_bus_model.stop_cond();
    xfer(1'b1, 4'h0, 32'h0);
    xfer(1'b1, 4'h4, 32'h400);
    i_i2c_bus_model.send_bits(9'h0a5, 8);
    rchk("status", 4'h0, 32'h0);
    @(posedge clk_i) receive_full_flag_i <= 1'b1;
    i_i2c_bus_model.send_bits(9'h0a5, 8);
    rchk("status", 4'h0, 32'h4);
    check("flags", {29'h0, flags_o}, 32'h4);
    tally_and_finish();
end
initial begin
    #300000;
    bad_count++;
    tally_and_finish();
end
endmodule // i2c_status_flags_test
